// ### pkg/sgps_defines.svh
// constants of the parameter set priority selector
`ifndef SGPS_DEFINES_SVH
`define SGPS_DEFINES_SVH

// ======================================================
// sizes
`define SGPS_NGRP 8
`define SGPS_NCOND 30
`define SGPS_AW 6
`define SGPS_DW 32
`define SGPS_CODE_NONE 4'h0
`define SGPS_CODE_MAX 4'h8

// ======================================================
// register byte offsets
`define SGPS_A_CTRL 6'h00
`define SGPS_A_USED 6'h04
`define SGPS_A_FORCE 6'h08
`define SGPS_A_REMOTE 6'h0c
`define SGPS_A_LOCAL 6'h10
`define SGPS_A_STATE 6'h14
`define SGPS_A_FILT_ON 6'h18
`define SGPS_A_FILT_OFF 6'h1c
`define SGPS_A_EVT_STAT 6'h20
`define SGPS_A_EVT_CLR 6'h24
`define SGPS_A_EVT_EN 6'h28
`define SGPS_A_STAMP 6'h2c

// ======================================================
// fields and reset values
`define SGPS_CTRL_FORCE 0
`define SGPS_ST_ACT_LSB 0
`define SGPS_ST_REQ_LSB 8
`define SGPS_ST_FORCE 16
`define SGPS_USED_RST 4'h1
`define SGPS_FILT_RST 30'h3fffffff

// ======================================================
// event condition indices
`define SGPS_C_REQ 0
`define SGPS_C_ACT 8
`define SGPS_C_ENA 16
`define SGPS_C_REM 24
`define SGPS_C_LOC 25
`define SGPS_C_FRC 26
`define SGPS_C_FNC 27
`define SGPS_C_FFF 28
`define SGPS_C_FPR 29

`endif

// ### pkg/sgps_pkg.sv
// types of the parameter set priority selector
`include "sgps_defines.svh"

package sgps_pkg;

  // ======================================================
  // bus and event carriers
  typedef struct packed {
    logic [`SGPS_AW-1:0] address;
    logic read;
    logic write;
    logic [`SGPS_DW-1:0] writedata;
  } sgps_avs_req_t;

  typedef struct packed {
    logic valid;
    logic on;
    logic [4:0] id;
    logic [31:0] stamp;
  } sgps_evt_t;

  typedef enum logic {
    SGPS_IDLE = 1'b0,
    SGPS_ANS = 1'b1
  } sgps_bus_t;

endpackage

// ### rtl/sgps_top.sv
// parameter set priority selector with event reporting
//
// Functional notes
// - fixed priority: set one highest, set eight lowest
// - each request input accepts a short pulse or a held level
// - held set one request blocks every other set request
// - held set two request admits only set one requests
// - held set five request drops six to eight, keeps one to four
// - held set eight request blocks nothing
// - active set returns to set one only on a set one request
// - event on each condition change, carrying a time stamp
// - per-event filter keeps rising, falling or both edges
// - on/off events for remote and local change requests
// - unconfigured target raises fail events, never activated
// - forced request failing its conditions raises fail events
// - request beaten by higher held request raises fail events
// - pulse-activated set stays latched until another request
// - forcing overrides inputs; only forced selection decides
// - remote request cannot pass a higher held set
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "sgps_defines.svh"

module sgps_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [`SGPS_NGRP-1:0] SG_REQ,
  input wire sgps_pkg::sgps_avs_req_t AVS_REQ,
  output logic [`SGPS_DW-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [`SGPS_NGRP-1:0] ACTIVE_SET,
  output sgps_pkg::sgps_evt_t EVT,
  output logic IRQ
);

  // ======================================================
  // state
  sgps_pkg::sgps_bus_t bus_state;
  logic [2:0] active;
  logic [3:0] used;
  logic force_en;
  logic frc_wr;
  logic [3:0] frc_code;
  logic [3:0] rem_code;
  logic [3:0] loc_code;
  logic [`SGPS_NGRP-1:0] req_q;
  logic fail_cfg;
  logic fail_frc;
  logic fail_pri;
  logic [`SGPS_NCOND-1:0] filt_on;
  logic [`SGPS_NCOND-1:0] filt_off;
  logic [`SGPS_NCOND-1:0] cond_q;
  logic [`SGPS_NCOND-1:0] pend_on;
  logic [`SGPS_NCOND-1:0] pend_off;
  logic [`SGPS_NCOND-1:0] evt_stat;
  logic [`SGPS_NCOND-1:0] evt_en;
  logic [31:0] stamp;

  // ======================================================
  // combinational signals
  logic acc;
  logic wr_go;
  logic [`SGPS_DW-1:0] rd_mux;
  logic [`SGPS_NGRP-1:0] used_mask;
  logic [`SGPS_NGRP-1:0] valid_in;
  logic [`SGPS_NGRP-1:0] blocked;
  logic [`SGPS_NGRP-1:0] asks;
  logic [`SGPS_NGRP-1:0] cand;
  logic hold_any;
  logic [2:0] hold_idx;
  logic [2:0] next_active;
  logic next_fail_cfg;
  logic next_fail_frc;
  logic next_fail_pri;
  logic [`SGPS_NCOND-1:0] cond;
  logic [`SGPS_NCOND-1:0] rise;
  logic [`SGPS_NCOND-1:0] fall;
  logic [`SGPS_NCOND-1:0] clr_on;
  logic [`SGPS_NCOND-1:0] clr_off;
  logic [`SGPS_NCOND-1:0] next_stat;
  logic emit;
  logic emit_on;
  logic [4:0] emit_id;

  function automatic logic [`SGPS_NGRP-1:0] decode(input logic [3:0] c);
    logic [`SGPS_NGRP-1:0] v;
    v = '0;
    if (c != `SGPS_CODE_NONE && c <= `SGPS_CODE_MAX) begin
      v[3'(c - 4'h1)] = 1'b1;
    end
    return v;
  endfunction

  // ======================================================
  // avalon slave: one wait cycle, answer on the second
  assign acc = (bus_state == sgps_pkg::SGPS_ANS);
  assign wr_go = acc && AVS_REQ.write;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_state <= sgps_pkg::SGPS_IDLE;
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      unique case (bus_state)
        sgps_pkg::SGPS_IDLE: begin
          if (AVS_REQ.read || AVS_REQ.write) begin
            bus_state <= sgps_pkg::SGPS_ANS;
            AVS_WAITREQUEST <= 1'b0;
          end
        end
        sgps_pkg::SGPS_ANS: begin
          bus_state <= sgps_pkg::SGPS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    rd_mux = '0;
    unique case (AVS_REQ.address)
      `SGPS_A_CTRL: rd_mux[`SGPS_CTRL_FORCE] = force_en;
      `SGPS_A_USED: rd_mux[3:0] = used;
      `SGPS_A_STATE: begin
        rd_mux[`SGPS_ST_ACT_LSB +: 3] = active;
        rd_mux[`SGPS_ST_REQ_LSB +: `SGPS_NGRP] = SG_REQ;
        rd_mux[`SGPS_ST_FORCE] = force_en;
      end
      `SGPS_A_FILT_ON: rd_mux[`SGPS_NCOND-1:0] = filt_on;
      `SGPS_A_FILT_OFF: rd_mux[`SGPS_NCOND-1:0] = filt_off;
      `SGPS_A_EVT_STAT: rd_mux[`SGPS_NCOND-1:0] = evt_stat;
      `SGPS_A_EVT_EN: rd_mux[`SGPS_NCOND-1:0] = evt_en;
      `SGPS_A_STAMP: rd_mux = stamp;
      // write-only and unmapped words read as zero
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      AVS_READDATA <= '0;
    end else if (!acc && AVS_REQ.read) begin
      AVS_READDATA <= rd_mux;
    end
  end

  // ======================================================
  // software settings
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      force_en <= 1'b0;
      used <= `SGPS_USED_RST;
      filt_on <= `SGPS_FILT_RST;
      filt_off <= `SGPS_FILT_RST;
      evt_en <= '0;
    end else if (wr_go) begin
      unique case (AVS_REQ.address)
        `SGPS_A_CTRL: force_en <= AVS_REQ.writedata[`SGPS_CTRL_FORCE];
        `SGPS_A_USED: begin
          // out-of-range counts are ignored, keeping at least one set in use
          if (AVS_REQ.writedata[3:0] != `SGPS_CODE_NONE &&
              AVS_REQ.writedata[3:0] <= `SGPS_CODE_MAX) begin
            used <= AVS_REQ.writedata[3:0];
          end
        end
        `SGPS_A_FILT_ON: filt_on <= AVS_REQ.writedata[`SGPS_NCOND-1:0];
        `SGPS_A_FILT_OFF: filt_off <= AVS_REQ.writedata[`SGPS_NCOND-1:0];
        `SGPS_A_EVT_EN: evt_en <= AVS_REQ.writedata[`SGPS_NCOND-1:0];
        default: begin
        end
      endcase
    end
  end

  // remote and local request strobes last one cycle, so each raises an on and an off event
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      frc_wr <= 1'b0;
      frc_code <= `SGPS_CODE_NONE;
      rem_code <= `SGPS_CODE_NONE;
      loc_code <= `SGPS_CODE_NONE;
    end else begin
      frc_wr <= wr_go && AVS_REQ.address == `SGPS_A_FORCE;
      frc_code <= AVS_REQ.writedata[3:0];
      rem_code <= (wr_go && AVS_REQ.address == `SGPS_A_REMOTE) ?
                  AVS_REQ.writedata[3:0] : `SGPS_CODE_NONE;
      loc_code <= (wr_go && AVS_REQ.address == `SGPS_A_LOCAL) ?
                  AVS_REQ.writedata[3:0] : `SGPS_CODE_NONE;
    end
  end

  // ======================================================
  // priority selection
  always_comb begin
    used_mask = '0;
    blocked = '0;
    hold_any = 1'b0;
    hold_idx = 3'h0;
    for (int i = 0; i < `SGPS_NGRP; i++) begin
      used_mask[i] = 4'(i) < used;
    end
    valid_in = SG_REQ & used_mask;
    // lowest index held wins; scanning down leaves the highest priority
    for (int i = `SGPS_NGRP - 1; i >= 0; i--) begin
      if (valid_in[i]) begin
        hold_any = 1'b1;
        hold_idx = 3'(i);
      end
    end
    // everything below the held set is refused, set eight refuses none
    for (int j = 0; j < `SGPS_NGRP; j++) begin
      blocked[j] = hold_any && 3'(j) > hold_idx;
    end
    asks = (SG_REQ & ~req_q) | decode(rem_code) | decode(loc_code);
    cand = valid_in | (asks & used_mask & ~blocked);
  end

  always_comb begin
    next_active = active;
    next_fail_cfg = 1'b0;
    next_fail_frc = 1'b0;
    next_fail_pri = 1'b0;
    if (force_en) begin
      // inputs and remote or local requests have no say here
      if (frc_wr) begin
        if ((decode(frc_code) & used_mask) != '0) begin
          next_active = 3'(frc_code - 4'h1);
        end else begin
          next_fail_frc = 1'b1;
        end
      end
    end else begin
      next_fail_frc = frc_wr;
      next_fail_cfg = (asks & ~used_mask) != '0;
      next_fail_pri = (asks & used_mask & blocked) != '0;
      for (int i = `SGPS_NGRP - 1; i >= 0; i--) begin
        if (cand[i]) begin
          next_active = 3'(i);
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      active <= 3'h0;
      ACTIVE_SET <= 8'h01;
      req_q <= '0;
      fail_cfg <= 1'b0;
      fail_frc <= 1'b0;
      fail_pri <= 1'b0;
    end else begin
      active <= next_active;
      ACTIVE_SET <= 8'h01 << next_active;
      req_q <= SG_REQ;
      fail_cfg <= next_fail_cfg;
      fail_frc <= next_fail_frc;
      fail_pri <= next_fail_pri;
    end
  end

  // ======================================================
  // event conditions and edge detection
  always_comb begin
    cond = '0;
    cond[`SGPS_C_REQ +: `SGPS_NGRP] = req_q;
    cond[`SGPS_C_ACT +: `SGPS_NGRP] = 8'h01 << active;
    cond[`SGPS_C_ENA +: `SGPS_NGRP] = used_mask;
    cond[`SGPS_C_REM] = rem_code != `SGPS_CODE_NONE;
    cond[`SGPS_C_LOC] = loc_code != `SGPS_CODE_NONE;
    cond[`SGPS_C_FRC] = force_en;
    cond[`SGPS_C_FNC] = fail_cfg;
    cond[`SGPS_C_FFF] = fail_frc;
    cond[`SGPS_C_FPR] = fail_pri;
    rise = cond & ~cond_q;
    fall = ~cond & cond_q;
  end

  // queue one pending edge per condition and direction; set wins over the emit clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cond_q <= {{(`SGPS_NCOND-`SGPS_C_ENA-1){1'b0}}, 1'b1,
                 {(`SGPS_C_ENA-`SGPS_C_ACT-1){1'b0}}, 1'b1,
                 {`SGPS_C_ACT{1'b0}}};
      pend_on <= '0;
      pend_off <= '0;
    end else begin
      cond_q <= cond;
      pend_on <= (pend_on & ~clr_on) | (rise & filt_on);
      pend_off <= (pend_off & ~clr_off) | (fall & filt_off);
    end
  end

  // one event leaves per cycle; a burst drains at the lowest index first
  always_comb begin
    emit = 1'b0;
    emit_on = 1'b0;
    emit_id = 5'h00;
    clr_on = '0;
    clr_off = '0;
    for (int i = `SGPS_NCOND - 1; i >= 0; i--) begin
      if (pend_on[i] || pend_off[i]) begin
        emit = 1'b1;
        emit_on = pend_on[i];
        emit_id = 5'(i);
      end
    end
    if (emit) begin
      clr_on[emit_id] = emit_on;
      clr_off[emit_id] = !emit_on;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stamp <= '0;
      EVT <= '0;
    end else begin
      stamp <= stamp + 32'h1;
      EVT.valid <= emit;
      EVT.on <= emit_on;
      EVT.id <= emit_id;
      EVT.stamp <= stamp;
    end
  end

  // ======================================================
  // interrupt status: any edge sets, clear write drops, set wins
  always_comb begin
    next_stat = evt_stat;
    if (wr_go && AVS_REQ.address == `SGPS_A_EVT_CLR) begin
      next_stat = next_stat & ~AVS_REQ.writedata[`SGPS_NCOND-1:0];
    end
    next_stat = next_stat | rise | fall;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      evt_stat <= '0;
      IRQ <= 1'b0;
    end else begin
      evt_stat <= next_stat;
      IRQ <= (next_stat & evt_en) != '0;
    end
  end

endmodule

// ### verification/sgps_req_src.sv
// request source standing in for inputs and logic signals
`timescale 1ns/1ps
module sgps_req_src (
  input wire logic [7:0] level,
  input wire logic [7:0] pulse,
  output logic [7:0] req
);
  // pulses last one clock, levels as long as held
  assign req = level | pulse;
endmodule

// ### verification/sgps_assertions.sv
// concurrent checks on the selector ports
`timescale 1ns/1ps
`include "sgps_defines.svh"
module sgps_chk (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] SG_REQ,
  input wire sgps_pkg::sgps_avs_req_t AVS_REQ,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [7:0] ACTIVE_SET,
  input wire sgps_pkg::sgps_evt_t EVT,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  logic frc;
  logic [3:0] used;
  logic wr;
  assign wr = AVS_REQ.write && !AVS_WAITREQUEST;
  // ======================================================
  // bus mirror: force enable and used count
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      frc <= 1'b0;
      used <= 4'h1;
    end else if (wr && AVS_REQ.address == `SGPS_A_CTRL) begin
      frc <= AVS_REQ.writedata[0];
    end else if (wr && AVS_REQ.address == `SGPS_A_USED) begin
      if (AVS_REQ.writedata != 0 && AVS_REQ.writedata < 32'h9) begin
        used <= AVS_REQ.writedata[3:0];
      end
    end
  end
  // ======================================================
  // properties
  sequence held_calm;
    (used == 4'h8 && !wr && !frc && SG_REQ != 8'h00 && $stable(SG_REQ))[*6];
  endsequence
  sequence bad_remote;
    wr && AVS_REQ.address == `SGPS_A_REMOTE && !frc && SG_REQ == 8'h00 &&
      AVS_REQ.writedata < 32'h9 && AVS_REQ.writedata[3:0] > used;
  endsequence
  chk_one_hot_set: assert property ($onehot(ACTIVE_SET))
    else $error("active set not one-hot");
  chk_lowest_held: assert property (held_calm |->
    ACTIVE_SET == (SG_REQ & (~SG_REQ + 8'h01)))
    else $error("held request of highest priority not active");
  chk_one_blocks: assert property ((SG_REQ[0] && !frc)[*4] |->
    ACTIVE_SET == 8'h01) else $error("held set one not active");
  chk_two_blocks: assert property (
    (SG_REQ[1:0] == 2'h2 && used > 4'h1 && !frc)[*5] |->
    ACTIVE_SET[7:2] == 6'h00) else $error("set below two active");
  chk_five_blocks: assert property (
    (SG_REQ[4:0] == 5'h10 && used > 4'h4 && !frc)[*5] |->
    ACTIVE_SET[7:5] == 3'h0) else $error("set below five active");
  chk_idle_holds: assert property (
    (SG_REQ == 8'h00 && !wr)[*5] |-> $stable(ACTIVE_SET))
    else $error("active set moved with no request");
  chk_force_freezes: assert property (
    (frc && !wr)[*5] |-> $stable(ACTIVE_SET))
    else $error("active set moved while forced");
  chk_unused_kept: assert property (bad_remote ##1
    (SG_REQ == 8'h00 && !wr)[*4] |-> ACTIVE_SET == $past(ACTIVE_SET, 3))
    else $error("unused set activated");
  chk_evt_follows: assert property (
    $changed(ACTIVE_SET) |-> ##[1:40] EVT.valid)
    else $error("no event after active set change");
  chk_stamp_rises: assert property (
    EVT.valid && $past(EVT.valid) |-> EVT.stamp > $past(EVT.stamp))
    else $error("event stamp not increasing");
endmodule
bind sgps_top sgps_chk chk_u (.CLK(CLK), .RST_N(RST_N), .SG_REQ(SG_REQ),
  .AVS_REQ(AVS_REQ), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .ACTIVE_SET(ACTIVE_SET), .EVT(EVT),
  .IRQ(IRQ));

// ### verification/tb_setting_group_priority_selector.sv
// self-checking bench of the priority selector
`timescale 1ns/1ps
`include "sgps_defines.svh"
module tb_setting_group_priority_selector;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] lvl = 8'h00;
  logic [7:0] pls = 8'h00;
  logic [7:0] sg_req;
  sgps_pkg::sgps_avs_req_t req = '0;
  logic [31:0] rd;
  logic [31:0] q;
  logic [7:0] act;
  sgps_pkg::sgps_evt_t evt;
  logic irq;
  logic wreq;
  logic [31:0] ev_on = 32'h0;
  logic [31:0] ev_off = 32'h0;
  logic ev_clr = 1'b0;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  sgps_req_src src_u (.level(lvl), .pulse(pls), .req(sg_req));
  sgps_top dut_u (.CLK(CLK), .RST_N(RST_N), .SG_REQ(sg_req),
    .AVS_REQ(req), .AVS_READDATA(rd), .AVS_WAITREQUEST(wreq),
    .ACTIVE_SET(act), .EVT(evt), .IRQ(irq));
  always #2 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    // one process owns the event record; scenarios clear it by strobe
    if (ev_clr) begin
      ev_on <= 32'h0;
      ev_off <= 32'h0;
    end else if (evt.valid === 1'b1 && evt.on === 1'b1) begin
      ev_on[evt.id] <= 1'b1;
    end else if (evt.valid === 1'b1 && evt.on === 1'b0) begin
      ev_off[evt.id] <= 1'b1;
    end
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ======================================================
  // helpers
  task automatic cmp(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // updates land within two edges; eight leaves margin
  task automatic cmp_set(input logic [7:0] e);
    repeat (8) @(posedge CLK);
    cmp("active set", {24'h0, e}, {24'h0, act});
  endtask
  task automatic bus(input logic w, input logic [5:0] a,
      input logic [31:0] d);
    req.address <= a;
    req.read <= !w;
    req.write <= w;
    req.writedata <= d;
    @(posedge CLK);
    while (wreq !== 1'b0) @(posedge CLK);
    q = rd;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] m,
      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp("read data", e, q & m);
  endtask
  task automatic pulse(input logic [7:0] m);
    pls <= m;
    @(posedge CLK);
    pls <= 8'h00;
  endtask
  task automatic clr_ev();
    ev_clr <= 1'b1;
    @(posedge CLK);
    ev_clr <= 1'b0;
  endtask
  // ======================================================
  // scenarios
  task automatic t_reset();
    cmp_set(8'h01);
    rdc(`SGPS_A_USED, '1, 32'h1);
    rdc(`SGPS_A_CTRL, '1, 32'h0);
    rdc(`SGPS_A_EVT_EN, '1, 32'h0);
    rdc(`SGPS_A_EVT_CLR, '1, 32'h0);
    rdc(6'h30, '1, 32'h0);
  endtask
  task automatic t_unused();
    wr(`SGPS_A_EVT_EN, 32'h1 << `SGPS_C_FNC);
    wr(`SGPS_A_REMOTE, 32'h3);
    cmp_set(8'h01);
    rdc(`SGPS_A_EVT_STAT, 32'h8000000, 32'h8000000);
    cmp("irq", 32'h1, {31'h0, irq});
    wr(`SGPS_A_EVT_CLR, '1);
    wr(`SGPS_A_EVT_EN, 32'h0);
    wr(`SGPS_A_REMOTE, 32'h3);
    cmp_set(8'h01);
    cmp("irq", 32'h0, {31'h0, irq});
  endtask
  task automatic t_prio();
    wr(`SGPS_A_USED, 32'h8);
    wr(`SGPS_A_USED, 32'h9);
    rdc(`SGPS_A_USED, '1, 32'h8);
    pulse(8'h08);
    cmp_set(8'h08);
    cmp_set(8'h08);
    lvl <= 8'h94;
    cmp_set(8'h04);
    lvl <= 8'h90;
    cmp_set(8'h10);
    lvl <= 8'h00;
    cmp_set(8'h10);
  endtask
  task automatic t_block();
    wr(`SGPS_A_EVT_CLR, '1);
    lvl <= 8'h10;
    pulse(8'h40);
    cmp_set(8'h10);
    rdc(`SGPS_A_EVT_STAT, 32'h20000000, 32'h20000000);
    lvl <= 8'h02;
    pulse(8'h04);
    cmp_set(8'h02);
    lvl <= 8'h03;
    pulse(8'h80);
    cmp_set(8'h01);
    lvl <= 8'h01;
    wr(`SGPS_A_REMOTE, 32'h2);
    cmp_set(8'h01);
    lvl <= 8'h00;
  endtask
  task automatic t_force();
    wr(`SGPS_A_EVT_CLR, '1);
    wr(`SGPS_A_FORCE, 32'h6);
    // the fail flag reaches status two edges after the write lands
    repeat (2) @(posedge CLK);
    rdc(`SGPS_A_EVT_STAT, 32'h10000000, 32'h10000000);
    wr(`SGPS_A_CTRL, 32'h1);
    rdc(`SGPS_A_STATE, 32'h10000, 32'h10000);
    wr(`SGPS_A_FORCE, 32'h6);
    cmp_set(8'h20);
    lvl <= 8'h01;
    cmp_set(8'h20);
    rdc(`SGPS_A_EVT_STAT, 32'h4000000, 32'h4000000);
    wr(`SGPS_A_CTRL, 32'h0);
    cmp_set(8'h01);
    lvl <= 8'h00;
  endtask
  task automatic t_events();
    logic [31:0] s;
    clr_ev();
    wr(`SGPS_A_REMOTE, 32'h3);
    cmp_set(8'h04);
    wr(`SGPS_A_LOCAL, 32'h5);
    cmp_set(8'h10);
    cmp("events", 32'h3001400, ev_on & 32'h3001400);
    wr(`SGPS_A_FILT_ON, ~(32'h1 << `SGPS_C_LOC));
    clr_ev();
    wr(`SGPS_A_LOCAL, 32'h2);
    cmp_set(8'h02);
    cmp("filtered", 32'h200, ev_on & 32'h2000200);
    wr(`SGPS_A_FILT_ON, 32'h3fffffff);
    wr(`SGPS_A_FILT_OFF, ~(32'h1 << `SGPS_C_REM));
    clr_ev();
    wr(`SGPS_A_REMOTE, 32'h3);
    cmp_set(8'h04);
    cmp("off filtered", 32'h200, ev_off & 32'h1000200);
    wr(`SGPS_A_FILT_OFF, 32'h3fffffff);
    // back-to-back reads capture three cycles apart
    bus(1'b0, `SGPS_A_STAMP, 32'h0);
    s = q;
    bus(1'b0, `SGPS_A_STAMP, 32'h0);
    cmp("stamp step", s + 32'h3, q);
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    t_reset();
    t_unused();
    t_prio();
    t_block();
    t_force();
    t_events();
    report_and_stop();
  end
endmodule
